// ### sxo_pkg.sv
// Package for the stack and exchange execution block
package sxo_pkg;
   // Opcodes and prefixes
   localparam logic [7:0] OP_PREFIX_FIRST  = 8'hdd;
   localparam logic [7:0] OP_PREFIX_SECOND = 8'hfd;
   localparam logic [7:0] OP_LOAD_SP_IDX   = 8'hf9;
   localparam logic [7:0] OP_PUSH_IDX      = 8'he5;
   localparam logic [7:0] OP_POP_IDX       = 8'he1;
   localparam logic [7:0] OP_SWAP_DE_HL    = 8'heb;
   localparam logic [7:0] OP_SWAP_AF       = 8'h08;
   // Pair push and pop patterns: 11qq0101 and 11qq0001
   localparam logic [7:0] OP_PAIR_MASK     = 8'hcf;
   localparam logic [7:0] OP_PUSH_PAIR     = 8'hc5;
   localparam logic [7:0] OP_POP_PAIR      = 8'hc1;
   localparam int         PAIR_SEL_MSB     = 5;
   localparam int         PAIR_SEL_LSB     = 4;
   // Pair select encodings
   localparam logic [1:0] SEL_COUNTER      = 2'h0;
   localparam logic [1:0] SEL_SECOND       = 2'h1;
   localparam logic [1:0] SEL_POINTER      = 2'h2;
   localparam logic [1:0] SEL_ACCUM        = 2'h3;
   // Clock-state totals per instruction
   localparam logic [4:0] T_LOAD_SP_IDX    = 5'h0a;
   localparam logic [4:0] T_PUSH_PAIR      = 5'h0b;
   localparam logic [4:0] T_PUSH_IDX       = 5'h0f;
   localparam logic [4:0] T_POP_PAIR       = 5'h0a;
   localparam logic [4:0] T_POP_IDX        = 5'h0e;
   localparam logic [4:0] T_SWAP           = 5'h04;
   // Machine cycle counts
   localparam logic [2:0] M_LOAD_SP_IDX    = 3'h2;
   localparam logic [2:0] M_PAIR           = 3'h3;
   localparam logic [2:0] M_IDX            = 3'h4;
   localparam logic [2:0] M_SWAP           = 3'h1;
   // Reset values
   localparam logic [15:0] RESET_WORD      = 16'hffff;

   // Register file of the core
   typedef struct packed {
      logic [15:0] pair_counter;
      logic [15:0] second_pair;
      logic [15:0] pair_pointer;
      logic [15:0] accum_flags_pair;
      logic [15:0] shadow_accum_flags;
      logic [15:0] index_first;
      logic [15:0] index_second;
      logic [15:0] stack_pointer;
   } sxo_regs_type;

   // Memory request
   typedef struct packed {
      logic        read;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sxo_mem_req_type;

   // Execution states
   typedef enum logic [2:0] {
      ST_FETCH, ST_PREFIXED, ST_WAIT, ST_FIRST_ACC, ST_SECOND_ACC
   } sxo_state_type;
endpackage : sxo_pkg

// ### sxo_core.sv
// Stack, index-load and exchange execution logic of an 8-bit core
`timescale 1ns/1ns
`default_nettype none

module sxo_core (
   // Clock and reset
   input  wire logic                   i_clock,
   input  wire logic                   i_reset_n,
   // Opcode byte stream
   input  wire logic                   i_op_valid,
   input  wire logic [7:0]             i_op_byte,
   output logic                        o_op_ready,
   // Stack memory
   output sxo_pkg::sxo_mem_req_type    o_mem_req,
   input  wire logic                   i_mem_done,
   input  wire logic [7:0]             i_mem_rdata,
   // Visible state
   output sxo_pkg::sxo_regs_type       o_regs,
   output logic                        o_instr_done,
   output logic [2:0]                  o_machine_cycles,
   output logic [4:0]                  o_clock_states
);
   // Current and next state
   sxo_pkg::sxo_state_type    state_reg, state_next;
   sxo_pkg::sxo_regs_type     regs_reg, regs_next;
   sxo_pkg::sxo_mem_req_type  req_reg, req_next;
   logic [7:0]  prefix_reg, prefix_next;     // Index prefix seen, zero if none
   logic        is_push_reg, is_push_next;   // Current stack transfer direction
   logic [1:0]  target_reg, target_next;     // Pair select, or index selector
   logic        use_index_reg, use_index_next;
   logic [7:0]  low_reg, low_next;           // Popped low byte held until high arrives
   logic [4:0]  wait_reg, wait_next;         // Remaining internal clock states
   logic        done_reg, done_next;
   logic [2:0]  mcyc_reg, mcyc_next;
   logic [4:0]  tst_reg, tst_next;

   // Opcode field decoding
   wire         is_push_pair = (i_op_byte & sxo_pkg::OP_PAIR_MASK) == sxo_pkg::OP_PUSH_PAIR;
   wire         is_pop_pair  = (i_op_byte & sxo_pkg::OP_PAIR_MASK) == sxo_pkg::OP_POP_PAIR;
   wire [1:0]   op_sel       = i_op_byte[sxo_pkg::PAIR_SEL_MSB:sxo_pkg::PAIR_SEL_LSB];
   wire         second_idx   = prefix_reg == sxo_pkg::OP_PREFIX_SECOND;
   wire [15:0]  sp_dec       = regs_reg.stack_pointer - 16'h0001;
   wire [15:0]  sp_inc       = regs_reg.stack_pointer + 16'h0001;
   wire [15:0]  src_word     = pick_word(regs_reg, use_index_reg, target_reg);
   wire         idle         = state_reg == sxo_pkg::ST_FETCH
                            || state_reg == sxo_pkg::ST_PREFIXED;

   // Source pair of a push, shared by the high and low write data bytes
   function automatic logic [15:0] pick_word(input sxo_pkg::sxo_regs_type r,
                                             input logic idx, input logic [1:0] sel);
      if (idx) begin
         pick_word = sel[0] ? r.index_second : r.index_first;
      end else begin
         case (sel)
            sxo_pkg::SEL_COUNTER: pick_word = r.pair_counter;
            sxo_pkg::SEL_SECOND:  pick_word = r.second_pair;
            sxo_pkg::SEL_POINTER: pick_word = r.pair_pointer;
            default:              pick_word = r.accum_flags_pair;
         endcase
      end
   endfunction : pick_word
   // Opcodes are taken only between stack transfers
   assign o_op_ready       = idle;
   assign o_mem_req        = req_reg;
   assign o_regs           = regs_reg;
   assign o_instr_done     = done_reg;
   assign o_machine_cycles = mcyc_reg;
   assign o_clock_states   = tst_reg;
   // Next-state logic
   always_comb begin
      logic [15:0] word;
      word           = 16'h0000;
      state_next     = state_reg;
      regs_next      = regs_reg;
      req_next       = req_reg;
      prefix_next    = prefix_reg;
      is_push_next   = is_push_reg;
      target_next    = target_reg;
      use_index_next = use_index_reg;
      low_next       = low_reg;
      wait_next      = wait_reg;
      done_next      = 1'b0;
      mcyc_next      = mcyc_reg;
      tst_next       = tst_reg;
      case (state_reg)
         sxo_pkg::ST_FETCH, sxo_pkg::ST_PREFIXED: begin
            if (i_op_valid) begin
               // Prefix byte seen: remember which index register
               if (state_reg == sxo_pkg::ST_FETCH
                   && (i_op_byte == sxo_pkg::OP_PREFIX_FIRST
                       || i_op_byte == sxo_pkg::OP_PREFIX_SECOND)) begin
                  prefix_next = i_op_byte;
                  state_next  = sxo_pkg::ST_PREFIXED;
               end else if (state_reg == sxo_pkg::ST_PREFIXED) begin
                  state_next  = sxo_pkg::ST_FETCH;
                  prefix_next = 8'h00;
                  if (i_op_byte == sxo_pkg::OP_LOAD_SP_IDX && second_idx) begin
                     regs_next.stack_pointer = regs_reg.index_second;
                     mcyc_next  = sxo_pkg::M_LOAD_SP_IDX;
                     tst_next   = sxo_pkg::T_LOAD_SP_IDX;
                     done_next  = 1'b1;
                  end else if (i_op_byte == sxo_pkg::OP_PUSH_IDX
                               || i_op_byte == sxo_pkg::OP_POP_IDX) begin
                     use_index_next = 1'b1;
                     target_next    = {1'b0, second_idx};
                     is_push_next   = i_op_byte == sxo_pkg::OP_PUSH_IDX;
                     mcyc_next      = sxo_pkg::M_IDX;
                     tst_next       = is_push_next ? sxo_pkg::T_PUSH_IDX : sxo_pkg::T_POP_IDX;
                     wait_next      = is_push_next ? 5'h1 : 5'h0;
                     state_next     = sxo_pkg::ST_WAIT;
                  end
               end else if (is_push_pair || is_pop_pair) begin
                  use_index_next = 1'b0;
                  target_next    = op_sel;
                  is_push_next   = is_push_pair;
                  mcyc_next      = sxo_pkg::M_PAIR;
                  tst_next       = is_push_pair ? sxo_pkg::T_PUSH_PAIR : sxo_pkg::T_POP_PAIR;
                  wait_next      = is_push_pair ? 5'h1 : 5'h0;
                  state_next     = sxo_pkg::ST_WAIT;
               end else if (i_op_byte == sxo_pkg::OP_SWAP_DE_HL) begin
                  regs_next.second_pair  = regs_reg.pair_pointer;
                  regs_next.pair_pointer = regs_reg.second_pair;
                  mcyc_next = sxo_pkg::M_SWAP;
                  tst_next  = sxo_pkg::T_SWAP;
                  done_next = 1'b1;
               end else if (i_op_byte == sxo_pkg::OP_SWAP_AF) begin
                  regs_next.accum_flags_pair   = regs_reg.shadow_accum_flags;
                  regs_next.shadow_accum_flags = regs_reg.accum_flags_pair;
                  mcyc_next = sxo_pkg::M_SWAP;
                  tst_next  = sxo_pkg::T_SWAP;
                  done_next = 1'b1;
               end
            end
         end
         sxo_pkg::ST_WAIT: begin
            // Extra internal state before the first stack access of a push
            if (wait_reg != 5'h00) begin
               wait_next = wait_reg - 5'h01;
            end else begin
               state_next = sxo_pkg::ST_FIRST_ACC;
               if (is_push_reg) begin
                  regs_next.stack_pointer = sp_dec;
                  req_next = '{read: 1'b0, write: 1'b1, addr: sp_dec,
                               wdata: src_word[15:8]};
               end else begin
                  req_next = '{read: 1'b1, write: 1'b0, addr: regs_reg.stack_pointer,
                               wdata: 8'h00};
               end
            end
         end
         sxo_pkg::ST_FIRST_ACC: begin
            // First byte moved; step pointer and issue the second access
            if (i_mem_done) begin
               state_next = sxo_pkg::ST_SECOND_ACC;
               if (is_push_reg) begin
                  regs_next.stack_pointer = sp_dec;
                  req_next = '{read: 1'b0, write: 1'b1, addr: sp_dec,
                               wdata: src_word[7:0]};
               end else begin
                  low_next = i_mem_rdata;
                  regs_next.stack_pointer = sp_inc;
                  req_next = '{read: 1'b1, write: 1'b0, addr: sp_inc, wdata: 8'h00};
               end
            end
         end
         default: begin
            // Second byte moved; pop writes the whole word at once
            if (i_mem_done) begin
               req_next   = '{read: 1'b0, write: 1'b0, addr: 16'h0000, wdata: 8'h00};
               state_next = sxo_pkg::ST_FETCH;
               done_next  = 1'b1;
               if (!is_push_reg) begin
                  regs_next.stack_pointer = sp_inc;
                  word = {i_mem_rdata, low_reg};
                  if (use_index_reg) begin
                     if (target_reg[0]) regs_next.index_second = word;
                     else regs_next.index_first = word;
                  end else begin
                     case (target_reg)
                        sxo_pkg::SEL_COUNTER: regs_next.pair_counter     = word;
                        sxo_pkg::SEL_SECOND:  regs_next.second_pair      = word;
                        sxo_pkg::SEL_POINTER: regs_next.pair_pointer     = word;
                        default:              regs_next.accum_flags_pair = word;
                     endcase
                  end
               end
            end
         end
      endcase
   end
   // State registers
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         state_reg     <= sxo_pkg::ST_FETCH;
         regs_reg      <= {8{sxo_pkg::RESET_WORD}};
         req_reg       <= '0;
         prefix_reg    <= 8'h00;
         is_push_reg   <= 1'b0;
         target_reg    <= 2'h0;
         use_index_reg <= 1'b0;
         low_reg       <= 8'h00;
         wait_reg      <= 5'h00;
         done_reg      <= 1'b0;
         mcyc_reg      <= 3'h0;
         tst_reg       <= 5'h00;
      end else begin
         state_reg     <= state_next;
         regs_reg      <= regs_next;
         req_reg       <= req_next;
         prefix_reg    <= prefix_next;
         is_push_reg   <= is_push_next;
         target_reg    <= target_next;
         use_index_reg <= use_index_next;
         low_reg       <= low_next;
         wait_reg      <= wait_next;
         done_reg      <= done_next;
         mcyc_reg      <= mcyc_next;
         tst_reg       <= tst_next;
      end
   end
   // Load of the stack pointer from the second index register
   property p_load_sp;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_PREFIXED && second_idx && i_op_valid
       && i_op_byte == sxo_pkg::OP_LOAD_SP_IDX)
      |=> regs_reg.stack_pointer == $past(regs_reg.index_second) && tst_reg == 5'h0a;
   endproperty
   a_load_sp: assert property (p_load_sp) else $error("stack load wrong");
   // Push writes high byte below the pointer
   property p_push_high;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_WAIT && is_push_reg && wait_reg == 5'h00)
      |=> req_reg.write && req_reg.addr == $past(regs_reg.stack_pointer) - 16'h0001
          && req_reg.wdata == $past(src_word[15:8]);
   endproperty
   a_push_high: assert property (p_push_high) else $error("push high wrong");
   // Pop reads first at the current pointer
   property p_pop_low;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_WAIT && !is_push_reg)
      |=> req_reg.read && req_reg.addr == $past(regs_reg.stack_pointer);
   endproperty
   a_pop_low: assert property (p_pop_low) else $error("pop address wrong");
   // Exchange of second pair and pointer pair
   property p_swap_de;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_FETCH && i_op_valid && i_op_byte == sxo_pkg::OP_SWAP_DE_HL)
      |=> regs_reg.second_pair == $past(regs_reg.pair_pointer)
          && regs_reg.pair_pointer == $past(regs_reg.second_pair);
   endproperty
   a_swap_de: assert property (p_swap_de) else $error("pair swap wrong");
   // Exchange of accumulator pair with shadow, both halves
   property p_swap_af;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_FETCH && i_op_valid && i_op_byte == sxo_pkg::OP_SWAP_AF)
      |=> regs_reg.accum_flags_pair == $past(regs_reg.shadow_accum_flags)
          && regs_reg.shadow_accum_flags == $past(regs_reg.accum_flags_pair) ##1 o_op_ready;
   endproperty
   a_swap_af: assert property (p_swap_af) else $error("shadow swap wrong");
   // Flags move only on their own swap or on a pop into the pair
   property p_flags;
      @(posedge i_clock) disable iff (!i_reset_n)
      !(state_reg == sxo_pkg::ST_FETCH && i_op_valid && i_op_byte == sxo_pkg::OP_SWAP_AF)
      && !(state_reg == sxo_pkg::ST_SECOND_ACC && !is_push_reg && !use_index_reg
           && target_reg == sxo_pkg::SEL_ACCUM) |=> $stable(regs_reg.accum_flags_pair);
   endproperty
   a_flags: assert property (p_flags) else $error("flags disturbed");
   // Pop pointer step, wrapping at the top of memory
   property p_wrap;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_FIRST_ACC && i_mem_done && !is_push_reg)
      |=> regs_reg.stack_pointer == $past(regs_reg.stack_pointer) + 16'h0001;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer step wrong");
   // Index push timing figures
   property p_idx_time;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == sxo_pkg::ST_PREFIXED && i_op_valid && i_op_byte == sxo_pkg::OP_PUSH_IDX)
      |=> mcyc_reg == 3'h4 && tst_reg == 5'h0f ##1 state_reg == sxo_pkg::ST_WAIT;
   endproperty
   a_idx_time: assert property (p_idx_time) else $error("index push timing");
endmodule : sxo_core
`default_nettype wire

// ### sxo_stack_mem.sv
// Behavioural stack memory that answers the core's byte requests
`timescale 1ns/1ns
`default_nettype none
module sxo_stack_mem #(
   parameter int SEED = 32'h1c0ffee1   // Seed of the answer delays
) (
   // Clock
   input  wire logic                     i_clock,
   // Requests from the core and answers
   input  wire sxo_pkg::sxo_mem_req_type i_mem_req,
   output logic                          o_mem_done,
   output logic [7:0]                    o_mem_rdata
);
   logic [7:0]  mem [65536];   // Whole 64 KiB address space
   logic [15:0] log_addr [2];  // Last two addresses served, oldest first
   int          seed;          // Delay generator state
   int          wait_cnt;      // Cycles left before the next answer

   // Start idle with a defined data bus
   initial begin
      seed        = SEED;
      wait_cnt    = 0;
      o_mem_done  = 1'b0;
      o_mem_rdata = 8'ha5;
   end

   // One access per done pulse; the delay varies so both quick and slow answers occur
   always @(posedge i_clock) begin
      if (o_mem_done) begin
         // Pulse over: pick the delay of the next answer
         o_mem_done  <= 1'b0;
         o_mem_rdata <= ~o_mem_rdata;
         wait_cnt    <= $unsigned($random(seed)) % 4;
      end else if ((i_mem_req.read || i_mem_req.write) && wait_cnt == 0) begin
         // Serve the standing request and remember its address
         o_mem_done  <= 1'b1;
         log_addr[0] <= log_addr[1];
         log_addr[1] <= i_mem_req.addr;
         if (i_mem_req.write) begin
            mem[i_mem_req.addr] <= i_mem_req.wdata;
         end else begin
            o_mem_rdata <= mem[i_mem_req.addr];
         end
      end else begin
         // Idle bus toggles so a stale byte is never mistaken for data
         o_mem_rdata <= ~o_mem_rdata;
         if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
endmodule : sxo_stack_mem
`default_nettype wire

// ### sxo_core_test.sv
// Self-checking bench for the stack and exchange execution block
`timescale 1ns/1ns
`default_nettype none
module sxo_core_test;
   // Design ports
   logic                     i_clock;
   logic                     i_reset_n;
   logic                     i_op_valid;
   logic [7:0]               i_op_byte;
   logic                     o_op_ready;
   sxo_pkg::sxo_mem_req_type o_mem_req;
   logic                     i_mem_done;
   logic [7:0]               i_mem_rdata;
   sxo_pkg::sxo_regs_type    o_regs;
   logic                     o_instr_done;
   logic [2:0]               o_machine_cycles;
   logic [4:0]               o_clock_states;
   // Bench state
   int                       n_fail;
   int                       comparisons;
   int                       seed;
   int                       i;
   sxo_pkg::sxo_regs_type    exp_regs;   // Expected register file
   logic [15:0]              ops [15];   // Prefix byte (00 for none) and opcode

   sxo_core sxo_core_inst (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_op_valid(i_op_valid),
      .i_op_byte(i_op_byte), .o_op_ready(o_op_ready), .o_mem_req(o_mem_req),
      .i_mem_done(i_mem_done), .i_mem_rdata(i_mem_rdata), .o_regs(o_regs),
      .o_instr_done(o_instr_done), .o_machine_cycles(o_machine_cycles),
      .o_clock_states(o_clock_states));

   sxo_stack_mem sxo_stack_mem_inst (
      .i_clock(i_clock), .i_mem_req(o_mem_req), .o_mem_done(i_mem_done),
      .o_mem_rdata(i_mem_rdata));

   // Free-running 100 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // Compare and count
   task automatic check(input logic [127:0] seen, input logic [127:0] want);
      comparisons++;
      if (seen !== want) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   // Verdict and end of run
   task automatic summarize;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Expected register file after one instruction
   function automatic sxo_pkg::sxo_regs_type predict(input sxo_pkg::sxo_regs_type r,
         input logic [15:0] code, input logic [15:0] word);
      sxo_pkg::sxo_regs_type n;
      n = r;
      case (code)
         16'h00c1: n.pair_counter     = word;
         16'h00d1: n.second_pair      = word;
         16'h00e1: n.pair_pointer     = word;
         16'h00f1: n.accum_flags_pair = word;
         16'hdde1: n.index_first      = word;
         16'hfde1: n.index_second     = word;
         16'hfdf9: n.stack_pointer    = r.index_second;
         16'h00eb: begin
            n.second_pair  = r.pair_pointer;
            n.pair_pointer = r.second_pair;
         end
         16'h0008: begin
            n.accum_flags_pair   = r.shadow_accum_flags;
            n.shadow_accum_flags = r.accum_flags_pair;
         end
         default: ;
      endcase
      // Pops end two up, pushes two down, both modulo 65536
      if (code[3:0] == 4'h1) n.stack_pointer = r.stack_pointer + 16'h0002;
      if (code[3:0] == 4'h5) n.stack_pointer = r.stack_pointer - 16'h0002;
      return n;
   endfunction : predict

   // Word that a push must place on the stack
   function automatic logic [15:0] push_src(input sxo_pkg::sxo_regs_type r,
         input logic [15:0] code);
      case (code)
         16'h00c5: return r.pair_counter;
         16'h00d5: return r.second_pair;
         16'h00e5: return r.pair_pointer;
         16'h00f5: return r.accum_flags_pair;
         16'hdde5: return r.index_first;
         default:  return r.index_second;
      endcase
   endfunction : push_src

   // Machine cycles and clock states of each instruction
   function automatic logic [7:0] timing(input logic [15:0] code);
      if (code == 16'hfdf9) return {3'h2, 5'h0a};
      if (code[15:8] != 8'h00) return (code[3:0] == 4'h5) ? {3'h4, 5'h0f} : {3'h4, 5'h0e};
      if (code[3:0] == 4'h5) return {3'h3, 5'h0b};
      if (code[3:0] == 4'h1) return {3'h3, 5'h0a};
      return {3'h1, 5'h04};
   endfunction : timing

   // Hold the byte until the core is seen ready at a falling edge, then through the next rising edge
   task automatic take;
      logic r;
      int   k;
      r = 1'b0;
      for (k = 0; k < 50 && !r; k++) begin
         @(negedge i_clock);
         r = (o_op_ready === 1'b1);
         @(posedge i_clock);
      end
      if (!r) begin
         n_fail++;
         summarize();
      end
   endtask : take

   // Issue one instruction, wait for completion and check every effect
   task automatic run(input logic [15:0] code);
      logic [15:0] sp0;
      logic [15:0] sp1;
      logic [15:0] spm1;
      logic [15:0] spm2;
      logic [15:0] word;
      logic [15:0] src;
      logic        r;
      int          k;
      sp0  = exp_regs.stack_pointer;
      sp1  = sp0 + 16'h0001;
      spm1 = sp0 - 16'h0001;
      spm2 = sp0 - 16'h0002;
      word = 16'($random(seed));
      src  = push_src(exp_regs, code);
      // Fresh stack bytes so every pop loads new data
      sxo_stack_mem_inst.mem[sp0] = word[7:0];
      sxo_stack_mem_inst.mem[sp1] = word[15:8];
      i_op_valid <= 1'b1;
      i_op_byte  <= (code[15:8] != 8'h00) ? code[15:8] : code[7:0];
      take();
      if (code[15:8] != 8'h00) begin
         i_op_byte <= code[7:0];
         take();
      end
      i_op_valid <= 1'b0;
      i_op_byte  <= 8'($random(seed));
      r = 1'b0;
      for (k = 0; k < 100 && !r; k++) begin
         @(negedge i_clock);
         r = (o_instr_done === 1'b1);
      end
      if (!r) begin
         n_fail++;
         summarize();
      end
      exp_regs = predict(exp_regs, code, word);
      check(128'(o_regs), 128'(exp_regs));
      check(128'({o_machine_cycles, o_clock_states}),
            128'(timing(code)));
      if (code[3:0] == 4'h1) begin
         check(128'({sxo_stack_mem_inst.log_addr[0], sxo_stack_mem_inst.log_addr[1]}),
               128'({sp0, sp1}));
      end
      if (code[3:0] == 4'h5) begin
         check(128'({sxo_stack_mem_inst.log_addr[0], sxo_stack_mem_inst.log_addr[1]}),
               128'({spm1, spm2}));
         check(128'({sxo_stack_mem_inst.mem[spm1], sxo_stack_mem_inst.mem[spm2]}),
               128'(src));
      end
      // Random gap, zero included, so some instructions start after a single idle cycle
      @(posedge i_clock);
      repeat ($unsigned($random(seed)) % 3) @(posedge i_clock);
   endtask : run

   // Main sequence: reset, every instruction once, then a random mix
   initial begin
      seed        = 32'h8653b1a8;
      n_fail      = 0;
      comparisons = 0;
      i_reset_n   = 1'b0;
      i_op_valid  = 1'b0;
      i_op_byte   = 8'h00;
      exp_regs    = {8{sxo_pkg::RESET_WORD}};
      // Pops first so the registers hold data before pushes and swaps
      ops = '{16'h00c1, 16'h00d1, 16'h00e1, 16'h00f1, 16'hdde1, 16'hfde1, 16'h00eb,
              16'h0008, 16'h00c5, 16'h00d5, 16'h00e5, 16'h00f5, 16'hdde5, 16'hfde5,
              16'hfdf9};
      repeat (20) @(posedge i_clock);
      i_reset_n <= 1'b1;
      @(negedge i_clock);
      check(128'(o_regs), 128'(exp_regs));
      check(128'(o_op_ready), 128'(1'b1));
      $display("reset test finished");
      @(posedge i_clock);
      // First pop starts at the top of memory, so its pointer wraps
      for (i = 0; i < 15; i++) begin
         run(ops[i]);
      end
      $display("directed test finished");
      for (i = 0; i < 60; i++) begin
         run(ops[$unsigned($random(seed)) % 15]);
      end
      $display("random test finished");
      summarize();
   end
endmodule : sxo_core_test
`default_nettype wire
